/* hw/cgmc_regs.svh */
// register offsets, field positions, reset values and counts of the
// clock generator mode controller; included by the design and the bench
`ifndef CGMC_REGS_SVH
`define CGMC_REGS_SVH

// ==========================================================
// byte offsets on the register bus
`define CGMC_OFF_CTRL      4'h0
`define CGMC_OFF_STATUS    4'h4
`define CGMC_OFF_FILTER    4'h8
`define CGMC_OFF_TRIM      4'hc

// ==========================================================
// control register fields
`define CGMC_CTRL_SEL_LO   0
`define CGMC_CTRL_REFERENCE_TYPE_SELECT     2
`define CGMC_CTRL_RANGE    3
`define CGMC_CTRL_KEEP     4
`define CGMC_CTRL_RDIV_LO  5
`define CGMC_CTRL_MULT_LO  8
`define CGMC_CTRL_WIDTH    15
`define CGMC_CTRL_RESET    15'h0000

// ==========================================================
// status register fields
`define CGMC_ST_MODE_LO    0
`define CGMC_ST_OSC_STABLE 3
`define CGMC_ST_LOCK       4
`define CGMC_ST_EXT_OK     5
`define CGMC_ST_CLK_LOSS   6
`define CGMC_ST_FEED       7

// ==========================================================
// reset values and loop counts
`define CGMC_FILTER_RESET  12'h200
`define CGMC_TRIM_RESET    8'h80
`define CGMC_XTAL_COUNT    4096
`define CGMC_LOCK_SAMPLES  4
`define CGMC_AVG_SAMPLES   4
`define CGMC_TRIM_BASE     10'h180

`endif

/* hw/cgmc_pkg.sv */
// types of the clock generator mode controller
// assumes nothing of its surroundings
package cgmc_pkg;

	// ==========================================================
	// operating modes, gray along scm-fei-fee-fbe-off
	typedef enum logic [2:0] {
		CGMC_SCM = 3'h0,
		CGMC_FEI = 3'h1,
		CGMC_FEE = 3'h3,
		CGMC_FBE = 3'h2,
		CGMC_OFF = 3'h6
	} cgmc_mode_t;

	// ==========================================================
	// control register, bit 0 at the bottom
	typedef struct packed {
		logic [6:0] mult;
		logic [2:0] rdiv;
		logic       keep;
		logic       range;
		logic       reference_type_select;
		logic [1:0] sel;
	} cgmc_ctrl_t;

	// ==========================================================
	// steering sent to oscillators and clock tree
	typedef struct packed {
		logic       feed_en;
		logic       osc_en;
		logic       irg_en;
		logic       ref_ext;
		logic       div_x2;
		logic       range_hi;
		logic [2:0] rdiv;
	} cgmc_clk_ctl_t;

endpackage

/* hw/cgmc_top.sv */
// clock generator mode controller: mode state machine, lock detector,
// loop filter, trim and an apb register slave
// assumes a count error per comparison from an outside pulse counter,
// loss monitors outside, and inputs synchronous to pclk
`timescale 1ns/10ps
`include "cgmc_regs.svh"

module cgmc_top import cgmc_pkg::*; #(
	parameter int               XTAL_COUNT = `CGMC_XTAL_COUNT,
	parameter logic [15:0]      NOM_PERIOD = 16'h0200,
	parameter logic [7:0]       N_LOCK     = 8'h02,
	parameter logic [7:0]       N_UNLOCK   = 8'h08
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [3:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                soft_rst,
	input  wire logic                cpu_stop,
	input  wire logic                debug_en,
	input  wire logic                ext_present,
	input  wire logic                ext_ref_tick,
	input  wire logic                ext_lost,
	input  wire logic                osc_lost,
	input  wire logic                osc_static,
	input  wire logic                cmp_valid,
	input  wire logic signed [11:0]  cmp_err,
	output cgmc_mode_t               mode_q,
	output cgmc_clk_ctl_t            clk_ctl_q,
	output logic [11:0]              filter_q,
	output logic [15:0]              irg_period_q,
	output logic [6:0]               mult_q
);

	// ==========================================================
	// state
	cgmc_ctrl_t          ctrl_q;
	cgmc_mode_t          mode_d;
	logic [7:0]          trim_q;
	logic [12:0]         xtal_cnt_q;
	logic                ext_ok_q;
	logic                loss_q;
	logic                osc_stable_flag_q;
	logic                in_unl_prev_q;
	logic                lock_q;
	logic                locked_once_q;
	logic [2:0]          lock_cnt_q;
	logic [1:0]          avg_cnt_q;
	logic signed [13:0]  avg_sum_q;
	logic                wait_osc_stable_flag_q;
	logic                ext_at_off_q;
	logic                stop_req;
	logic                wr_en;
	logic [11:0]         err_abs;
	logic                in_lock;
	logic                in_unlock;
	logic                xtal_done;
	logic signed [13:0]  sum_d;

	assign stop_req  = cpu_stop && !debug_en;
	assign wr_en     = ce && psel && penable && pwrite && pready;
	assign err_abs   = cmp_err[11] ? 12'(-cmp_err) : 12'(cmp_err);
	assign in_lock   = err_abs <= {4'h0, N_LOCK};
	assign in_unlock = err_abs <= {4'h0, N_UNLOCK};
	assign xtal_done = xtal_cnt_q >= 13'(XTAL_COUNT);
	assign sum_d     = avg_sum_q + 14'(cmp_err);
	assign mult_q    = ctrl_q.mult;

	// ==========================================================
	// mode transitions
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			CGMC_OFF: begin
				if (!cpu_stop) begin
					if (ctrl_q.sel == 2'h2 && ext_at_off_q)
						mode_d = CGMC_FBE;
					else
						mode_d = CGMC_SCM;
				end
			end
			CGMC_SCM: begin
				if (stop_req)
					mode_d = CGMC_OFF;
				else if (ctrl_q.sel == 2'h1 && !wait_osc_stable_flag_q)
					mode_d = CGMC_FEI;
				else if (ctrl_q.sel == 2'h1 && osc_stable_flag_q)
					mode_d = CGMC_FEI;
				else if (ctrl_q.sel == 2'h3 && ext_ok_q && osc_stable_flag_q)
					mode_d = CGMC_FEE;
				else if (ctrl_q.sel == 2'h2 && ext_ok_q)
					mode_d = CGMC_FBE;
			end
			CGMC_FEI: begin
				if (stop_req)
					mode_d = CGMC_OFF;
				else if (ctrl_q.sel != 2'h1)
					mode_d = CGMC_SCM;
			end
			CGMC_FEE: begin
				if (stop_req)
					mode_d = CGMC_OFF;
				else if (ext_lost && !ext_ok_q)
					mode_d = CGMC_SCM;
				else if (osc_lost && ext_ok_q)
					mode_d = CGMC_FBE;
				else if (ctrl_q.sel != 2'h3)
					mode_d = CGMC_SCM;
			end
			CGMC_FBE: begin
				if (stop_req)
					mode_d = CGMC_OFF;
				else if (ctrl_q.sel != 2'h2 || (ext_lost && !ext_ok_q))
					mode_d = CGMC_SCM;
			end
			default: mode_d = CGMC_SCM;
		endcase
	end

	// ==========================================================
	// mode register
	// single mode register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= CGMC_SCM;
		end else if (ce) begin
			if (soft_rst)
				mode_q <= CGMC_SCM;
			else
				mode_q <= mode_d;
		end
	end

	// wake-up bookkeeping taken as the off state is entered and left
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_osc_stable_flag_q  <= 1'b0;
			ext_at_off_q <= 1'b0;
		end else if (ce) begin
			if (soft_rst) begin
				wait_osc_stable_flag_q  <= 1'b0;
				ext_at_off_q <= 1'b0;
			end else begin
				if (mode_q != CGMC_OFF && mode_d == CGMC_OFF)
					ext_at_off_q <= ext_ok_q;
				// hold scm until stable, only for x1 select
				if (mode_q == CGMC_OFF && mode_d == CGMC_SCM &&
				    ctrl_q.sel[0])
					wait_osc_stable_flag_q <= 1'b1;
				// a new control write ends the wait, a written 01 enters fei
				else if (osc_stable_flag_q || mode_q != CGMC_SCM ||
				         (wr_en && paddr == `CGMC_OFF_CTRL))
					wait_osc_stable_flag_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// control register; mcu reset restores it, trim is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CGMC_CTRL_RESET;
		end else if (ce) begin
			if (soft_rst)
				ctrl_q <= `CGMC_CTRL_RESET;
			else if (wr_en && paddr == `CGMC_OFF_CTRL)
				ctrl_q <= pwdata[`CGMC_CTRL_WIDTH-1:0];
			else if (mode_q == CGMC_FEE && mode_d == CGMC_FBE)
				ctrl_q.sel <= 2'h2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			trim_q <= `CGMC_TRIM_RESET;
		else if (ce && wr_en && paddr == `CGMC_OFF_TRIM)
			trim_q <= pwdata[7:0];
	end

	// period = nominal*(384+trim)/512, 0.75 to 1.25
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irg_period_q <= 16'h0000;
		else if (ce)
			irg_period_q <= 16'((26'(NOM_PERIOD) *
				26'(`CGMC_TRIM_BASE + {2'h0, trim_q})) >> 9);
	end

	// ==========================================================
	// external reference qualification
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_cnt_q <= 13'h0000;
			ext_ok_q   <= 1'b0;
		end else if (ce) begin
			if (soft_rst || !ext_present ||
			    (mode_q == CGMC_OFF && !ctrl_q.keep))
				xtal_cnt_q <= 13'h0000;
			else if (ctrl_q.reference_type_select && ext_ref_tick && !xtal_done)
				xtal_cnt_q <= xtal_cnt_q + 13'h0001;
			ext_ok_q <= !soft_rst && ext_present &&
				(!ctrl_q.reference_type_select || xtal_done);
		end
	end

	// clock loss flag, write one clears, a new loss wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			loss_q <= 1'b0;
		else if (ce) begin
			if (soft_rst)
				loss_q <= 1'b0;
			else if (ext_lost || osc_lost)
				loss_q <= 1'b1;
			else if (wr_en && paddr == `CGMC_OFF_STATUS &&
			         pwdata[`CGMC_ST_CLK_LOSS])
				loss_q <= 1'b0;
		end
	end

	// ==========================================================
	// stable flag and lock detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_stable_flag_q        <= 1'b0;
			in_unl_prev_q <= 1'b0;
		end else if (ce) begin
			if (soft_rst || mode_q == CGMC_OFF) begin
				osc_stable_flag_q        <= 1'b0;
				in_unl_prev_q <= 1'b0;
			end else if (cmp_valid) begin
				in_unl_prev_q <= in_unlock;
				osc_stable_flag_q <= in_unlock && in_unl_prev_q && !osc_static;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_q        <= 1'b0;
			lock_cnt_q    <= 3'h0;
			locked_once_q <= 1'b0;
		end else if (ce) begin
			if (soft_rst || (mode_q != CGMC_FEI && mode_q != CGMC_FEE)) begin
				lock_q        <= 1'b0;
				lock_cnt_q    <= 3'h0;
				locked_once_q <= 1'b0;
			end else if (cmp_valid) begin
				if (lock_q && !in_unlock) begin
					lock_q     <= 1'b0;
					lock_cnt_q <= 3'h0;
				end else if (!lock_q && !in_lock) begin
					lock_cnt_q <= 3'h0;
				end else if (!lock_q) begin
					lock_cnt_q <= lock_cnt_q + 3'h1;
					if (lock_cnt_q == 3'(`CGMC_LOCK_SAMPLES - 1)) begin
						lock_q        <= 1'b1;
						locked_once_q <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================
	// loop filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_q  <= `CGMC_FILTER_RESET;
			avg_cnt_q <= 2'h0;
			avg_sum_q <= 14'sh0000;
		end else if (ce) begin
			// reset filter to nominal start frequency
			if (soft_rst) begin
				filter_q  <= `CGMC_FILTER_RESET;
				avg_cnt_q <= 2'h0;
				avg_sum_q <= 14'sh0000;
			end else if (mode_q == CGMC_SCM) begin
				if (wr_en && paddr == `CGMC_OFF_FILTER)
					filter_q <= pwdata[11:0];
				avg_cnt_q <= 2'h0;
				avg_sum_q <= 14'sh0000;
			end else if ((mode_q == CGMC_FEI || mode_q == CGMC_FEE) &&
			             cmp_valid) begin
				if (!lock_q) begin
					filter_q <= filter_q + 12'(cmp_err);
				end else if (avg_cnt_q == 2'(`CGMC_AVG_SAMPLES - 1)) begin
					filter_q  <= filter_q + 12'(sum_d >>> 2);
					avg_cnt_q <= 2'h0;
					avg_sum_q <= 14'sh0000;
				end else begin
					avg_cnt_q <= avg_cnt_q + 2'h1;
					avg_sum_q <= sum_d;
				end
			end
		end
	end

	// ==========================================================
	// clock steering; a one cycle lag behind the mode is accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_ctl_q <= '0;
		end else if (ce) begin
			// feed off in stop and on unstable bypass
			clk_ctl_q.feed_en <= mode_q != CGMC_OFF &&
				!(mode_q == CGMC_FBE && !ext_ok_q);
			clk_ctl_q.osc_en  <= mode_q != CGMC_FBE &&
				(mode_q != CGMC_OFF || ctrl_q.keep);
			clk_ctl_q.irg_en  <= mode_q != CGMC_FBE &&
				(mode_q != CGMC_OFF || ctrl_q.keep);
			clk_ctl_q.ref_ext <= mode_q == CGMC_FBE ||
				(mode_q == CGMC_FEE && ext_ok_q);
			clk_ctl_q.div_x2  <= mode_q == CGMC_FEE && !lock_q &&
				!locked_once_q;
			clk_ctl_q.range_hi <= ctrl_q.reference_type_select && ctrl_q.range;
			clk_ctl_q.rdiv     <= ctrl_q.rdiv;
		end
	end

	// ==========================================================
	// apb slave, one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr[1:0] != 2'h0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`CGMC_OFF_CTRL:
						prdata <= {17'h0, ctrl_q};
					`CGMC_OFF_STATUS:
						prdata <= {24'h0, clk_ctl_q.feed_en, loss_q,
							ext_ok_q, lock_q, osc_stable_flag_q, mode_q};
					`CGMC_OFF_FILTER:
						prdata <= {20'h0, filter_q};
					`CGMC_OFF_TRIM:
						prdata <= {24'h0, trim_q};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_STOP_OFF: assert property (
		ce && !soft_rst && stop_req && mode_q != CGMC_OFF |=>
		mode_q == CGMC_OFF) else $error("stop did not reach off");
	AST_DEBUG_RUN: assert property (
		debug_en && ce && mode_q != CGMC_OFF |=> mode_q != CGMC_OFF)
		else $error("debug stop halted clocks");
	AST_KEEP_OSC: assert property (
		ce && mode_q == CGMC_OFF && ctrl_q.keep |=>
		clk_ctl_q.osc_en && !clk_ctl_q.feed_en)
		else $error("keep in stop not honoured");
	AST_BYP_GATE: assert property (
		ce && mode_q == CGMC_FBE && !ext_ok_q |=> !clk_ctl_q.feed_en)
		else $error("bypass output before ext stable");
	AST_RST_SCM: assert property (
		ce && soft_rst |=> mode_q == CGMC_SCM && $stable(trim_q))
		else $error("mcu reset not to scm or trim lost");
	AST_XTAL_WAIT: assert property (
		ext_ok_q && ctrl_q.reference_type_select && $past(ctrl_q.reference_type_select) |->
		$past(xtal_done)) else $error("crystal used before count");
	AST_FILT_LOCK: assert property (
		ce && mode_q == CGMC_OFF |=> $stable(filter_q))
		else $error("filter changed in off");
	AST_WAIT_STABLE: assert property (
		ce && mode_q == CGMC_SCM && wait_osc_stable_flag_q && !osc_stable_flag_q &&
		!stop_req && !soft_rst && ctrl_q.sel[0] |=> mode_q == CGMC_SCM)
		else $error("loop closed before stable");
	AST_BYP_ENTRY: assert property (
		ce && !soft_rst && !stop_req && mode_q == CGMC_SCM &&
		ctrl_q.sel == 2'h2 && ext_ok_q |=> mode_q == CGMC_FBE)
		else $error("bypass not entered");
	AST_BYP_OFF: assert property (
		ce && mode_q == CGMC_FBE |=> !clk_ctl_q.osc_en && !clk_ctl_q.irg_en)
		else $error("oscillator running in bypass");
	AST_OFF_CLR: assert property (
		ce && mode_q == CGMC_OFF |=> !osc_stable_flag_q)
		else $error("stable flag kept in off");

	COV_FEI_LOCK: cover property (mode_q == CGMC_FEI && $rose(lock_q));
	COV_STOP_WAKE: cover property (mode_q == CGMC_OFF ##1
		mode_q == CGMC_SCM);
	COV_FEE_TO_FBE: cover property (mode_q == CGMC_FEE ##1
		mode_q == CGMC_FBE);

endmodule

/* dv/cgmc_ext_model.sv */
// external clock source model: presence level and reference ticks
// assumes pclk and presetn from the bench; no ticks while run is low, only the one loss pulse after it falls
`timescale 1ns/10ps

module cgmc_ext_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	output logic      ext_present,
	output logic      ext_ref_tick,
	output logic      ext_lost
);
	logic [1:0] div_q;
	logic       run_q;

	// ==========================================================
	// reference ticks
	// source slow, a third of pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 2'h0;
			ext_ref_tick <= 1'b0;
			run_q <= 1'b0;
			ext_lost <= 1'b0;
		end else begin
			div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
			ext_ref_tick <= run && (div_q == 2'h2);
			run_q <= run;
			ext_lost <= run_q && !run;
		end
	end

	// a stopped source is reported lost one cycle later, as a pulse
	assign ext_present = run;
endmodule

/* dv/tb_top.sv */
// self-checking bench of the clock generator mode controller
// assumes the apb slave answers with pready and the source model
`timescale 1ns/10ps
`include "cgmc_regs.svh"

module tb_top;
	import cgmc_pkg::*;
	localparam logic [15:0] NOM = 16'h0200;
	logic               pclk, presetn, psel, penable, pwrite;
	logic [3:0]         paddr;
	logic [31:0]        pwdata, prdata, rd_q, f;
	logic               pready, pslverr, err_q, soft_rst, cpu_stop;
	logic               debug_en, run, ext_present, ext_ref_tick, ext_lost;
	logic               cmp_valid, ce, osc_lost;
	logic signed [11:0] cmp_err;
	cgmc_mode_t         mode_q;
	cgmc_clk_ctl_t      clk_ctl_q;
	logic [11:0]        filter_q;
	logic [15:0]        irg_period_q;
	logic [6:0]         mult_q, m;
	logic [7:0]         t;
	int                 err_count, n_compared, cycles, n;

	cgmc_top #(.XTAL_COUNT(8), .NOM_PERIOD(NOM)) cgmc_top_i (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .soft_rst(soft_rst), .cpu_stop(cpu_stop),
		.debug_en(debug_en), .ext_present(ext_present),
		.ext_ref_tick(ext_ref_tick), .ext_lost(ext_lost),
		.osc_lost(osc_lost), .osc_static(1'b0), .cmp_valid(cmp_valid),
		.cmp_err(cmp_err), .mode_q(mode_q), .clk_ctl_q(clk_ctl_q),
		.filter_q(filter_q), .irg_period_q(irg_period_q),
		.mult_q(mult_q));

	cgmc_ext_model cgmc_ext_model_i (
		.pclk(pclk), .presetn(presetn), .run(run),
		.ext_present(ext_present), .ext_ref_tick(ext_ref_tick),
		.ext_lost(ext_lost));

	// ==========================================================
	// clock, timeout and helpers
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask

	// an idle edge before setup keeps psel from two writes in one step
	task automatic apb(input logic w, input logic [3:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task automatic sample(input logic signed [11:0] e);
		@(posedge pclk);
		cmp_valid <= 1'b1;
		cmp_err <= e;
		@(posedge pclk);
		cmp_valid <= 1'b0;
	endtask

	task automatic stop(input logic s);
		cpu_stop <= s;
		cyc(3);
	endtask

	function automatic logic [15:0] exp_period(input logic [7:0] v);
		return 16'((32'(NOM) * (32'd384 + 32'(v))) / 32'd512);
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, soft_rst, cpu_stop} = '0;
		{debug_en, run, cmp_valid, osc_lost} = '0;
		ce = 1'b1;
		{paddr, pwdata, cmp_err} = '0;
		void'($urandom(25944));
		cyc(8);
		presetn <= 1'b1;
		apb(0, `CGMC_OFF_TRIM, 0);
		chk("trim reset", 32'h80, rd_q);
		apb(0, `CGMC_OFF_CTRL, 0);
		chk("ctrl reset", 32'h0, rd_q);
		apb(0, `CGMC_OFF_STATUS, 0);
		chk("mode reset", 32'(CGMC_SCM), {29'h0, rd_q[2:0]});
		apb(0, 4'h1, 0);
		chk("misaligned", 32'h1, {31'h0, err_q});
		for (int i = 0; i < 6; i++) begin
			t = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			apb(1, `CGMC_OFF_TRIM, {24'h0, t});
			cyc(2);
			chk("period", {16'h0, exp_period(t)}, {16'h0, irg_period_q});
		end
		apb(1, `CGMC_OFF_FILTER, 32'h0ab);
		apb(0, `CGMC_OFF_FILTER, 0);
		chk("filter scm", 32'h0ab, rd_q);
		debug_en <= 1'b1;
		stop(1);
		chk("debug mode", 32'(CGMC_SCM), 32'(mode_q));
		chk("debug feed", 32'h1, {31'h0, clk_ctl_q.feed_en});
		stop(0);
		debug_en <= 1'b0;
		stop(1);
		chk("stop mode", 32'(CGMC_OFF), 32'(mode_q));
		chk("stop feed", 32'h0, {31'h0, clk_ctl_q.feed_en});
		stop(0);
		chk("wake mode", 32'(CGMC_SCM), 32'(mode_q));
		apb(1, `CGMC_OFF_CTRL, 32'h10);
		stop(1);
		chk("keep feed", 32'h0, {31'h0, clk_ctl_q.feed_en});
		chk("keep osc", 32'h1, {31'h0, clk_ctl_q.osc_en});
		stop(0);
		apb(0, `CGMC_OFF_CTRL, 0);
		chk("wake ctrl", 32'h10, rd_q);
		chk("wake feed", 32'h1, {31'h0, clk_ctl_q.feed_en});
		m = 7'($urandom);
		apb(1, `CGMC_OFF_CTRL, {17'h0, m, 8'h01});
		cyc(2);
		chk("fei mode", 32'(CGMC_FEI), 32'(mode_q));
		chk("mult", {25'h0, m}, {25'h0, mult_q});
		apb(1, `CGMC_OFF_FILTER, 32'h123);
		apb(0, `CGMC_OFF_FILTER, 0);
		chk("filter fei", 32'h0ab, rd_q);
		repeat (4) sample(12'sd0);
		cyc(2);
		apb(0, `CGMC_OFF_STATUS, 0);
		chk("lock", 32'h1, {31'h0, rd_q[4]});
		chk("stable", 32'h1, {31'h0, rd_q[3]});
		apb(0, `CGMC_OFF_FILTER, 0);
		f = rd_q;
		repeat (8) sample(12'sd1);
		cyc(2);
		apb(0, `CGMC_OFF_FILTER, 0);
		chk("filter avg", f + 32'h2, rd_q);
		stop(1);
		apb(0, `CGMC_OFF_STATUS, 0);
		chk("off status", 32'h6, {28'h0, rd_q[3:0]});
		stop(0);
		chk("x1 wake", 32'(CGMC_SCM), 32'(mode_q));
		repeat (3) sample(12'sd0);
		cyc(2);
		chk("close loop", 32'(CGMC_FEI), 32'(mode_q));
		apb(1, `CGMC_OFF_CTRL, 32'h0);
		cyc(2);
		chk("x1 to 00", 32'(CGMC_SCM), 32'(mode_q));
		apb(1, `CGMC_OFF_CTRL, 32'h0e);
		cyc(6);
		chk("no ticks", 32'(CGMC_SCM), 32'(mode_q));
		run <= 1'b1;
		n = 0;
		while (mode_q !== CGMC_FBE && n < 200) begin
			cyc(1);
			n++;
		end
		chk("xtal wait", 32'h1, {31'h0, n >= 21});
		chk("fbe mode", 32'(CGMC_FBE), 32'(mode_q));
		cyc(2);
		chk("fbe osc", 32'h0, {31'h0, clk_ctl_q.osc_en});
		chk("fbe irg", 32'h0, {31'h0, clk_ctl_q.irg_en});
		chk("range", 32'h1, {31'h0, clk_ctl_q.range_hi});
		apb(1, `CGMC_OFF_CTRL, 32'h0f);
		cyc(4);
		chk("fee mode", 32'(CGMC_FEE), 32'(mode_q));
		chk("fee div", 32'h1, {31'h0, clk_ctl_q.div_x2});
		chk("fee ref", 32'h1, {31'h0, clk_ctl_q.ref_ext});
		osc_lost <= 1'b1;
		cyc(1);
		osc_lost <= 1'b0;
		cyc(2);
		chk("osc loss", 32'(CGMC_FBE), 32'(mode_q));
		chk("fbe div", 32'h0, {31'h0, clk_ctl_q.div_x2});
		apb(0, `CGMC_OFF_CTRL, 0);
		chk("loss sel", 32'h2, {30'h0, rd_q[1:0]});
		apb(0, `CGMC_OFF_STATUS, 0);
		chk("loss flag", 32'h1, {31'h0, rd_q[6]});
		apb(1, `CGMC_OFF_STATUS, 32'h40);
		apb(0, `CGMC_OFF_STATUS, 0);
		chk("loss clear", 32'h0, {31'h0, rd_q[6]});
		run <= 1'b0;
		cyc(3);
		chk("ref missing", 32'(CGMC_SCM), 32'(mode_q));
		ce <= 1'b0;
		stop(1);
		chk("ce freeze", 32'(CGMC_SCM), 32'(mode_q));
		ce <= 1'b1;
		stop(0);
		soft_rst <= 1'b1;
		cyc(1);
		soft_rst <= 1'b0;
		cyc(2);
		chk("rst mode", 32'(CGMC_SCM), 32'(mode_q));
		apb(0, `CGMC_OFF_CTRL, 0);
		chk("rst ctrl", 32'h0, rd_q);
		apb(0, `CGMC_OFF_TRIM, 0);
		chk("rst trim", {24'h0, t}, rd_q);
		complete_run();
	end
endmodule
